/* logic/agc_avg.sv */
`timescale 1ns/1ps
module agc_avg import agc_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  agc_avg_if.avgr  link
);
  logic [13:0] sum;
  logic [13:0] next_sum;
  logic [6:0]  cnt;
  logic [6:0]  next_cnt;
  logic [1:0]  lenQ;
  logic [1:0]  next_lenQ;
  logic        busy;
  logic        next_busy;
  logic        done;
  logic        next_done;
  logic [7:0]  avg;
  logic [7:0]  next_avg;

  // The length is caught at the window start so one window never mixes two.
  always_comb begin
    logic [13:0] acc;
    acc       = sum + {6'h00, link.sampleMag};
    next_sum  = sum;
    next_cnt  = cnt;
    next_lenQ = lenQ;
    next_busy = busy;
    next_done = 1'b0;
    next_avg  = avg;
    if (link.start) begin
      next_sum  = 14'h0000;
      next_cnt  = 7'h00;
      next_lenQ = link.lenSel;
      next_busy = 1'b1;
    end else if (busy && link.sampleValid) begin
      if (cnt == AVG_SAMPLES[lenQ] - 7'h01) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_avg  = 8'(acc >> AVG_SHIFT[lenQ]);
      end else begin
        next_sum = acc;
        next_cnt = cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sum  <= 14'h0000;
      cnt  <= 7'h00;
      lenQ <= 2'h0;
      busy <= 1'b0;
      done <= 1'b0;
      avg  <= 8'h00;
    end else begin
      sum  <= next_sum;
      cnt  <= next_cnt;
      lenQ <= next_lenQ;
      busy <= next_busy;
      done <= next_done;
      avg  <= next_avg;
    end
  end

  assign link.done = done;
  assign link.avg  = avg;

  a_avg_len: assert property (@(posedge clock) disable iff (rst)
    link.done |-> $past(busy) && $past(cnt) == AVG_SAMPLES[lenQ] - 7'h01)
    else $error("Average window ended at the wrong sample count.");
endmodule

/* logic/agc_avg_if.sv */
`timescale 1ns/1ps
interface agc_avg_if;
  logic [1:0] lenSel;
  logic       start;
  logic       sampleValid;
  logic [7:0] sampleMag;
  logic       done;
  logic [7:0] avg;
  modport ctl (output lenSel, start, sampleValid, sampleMag,
               input done, avg);
  modport avgr (input lenSel, start, sampleValid, sampleMag,
                output done, avg);
endinterface

/* logic/agc_gain_loop.sv */
// What this block does
// - Two-bit hysteresis field in bits 7:6 shapes gain decisions, resets to 2.
// - Settings 0..3 give none, low, medium, large hysteresis and small to large dead zones.
// - After each gain step wait 8, 16, 24 or 32 samples; reset 1.
// - Hold field bits 3:2 at 0, reset value, adjusts gain whenever needed.
// - Hold setting 1 stops gain changes once a sync word was found.
// - Hold setting 2 keeps analogue gain, still adjusts digital gain.
// - Hold setting 3 keeps both gains fixed for manual override.
// - Average amplitude over 8, 16, 32 or 64 samples; reset setting 1.
// - In OOK mode the length field sets a 4 to 16 dB decision boundary.
// - The whole configuration is one read/write 8-bit register at 0x1C.
`timescale 1ns/1ps
module agc_gain_loop import agc_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [5:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       sampleValid,
  input  wire logic [7:0] sampleMag,
  input  wire logic       syncFound,
  input  wire logic       rxStart,
  input  wire logic       ookMode,
  output logic      [2:0] analogGain,
  output logic      [2:0] digitalGain,
  output logic            gainStep,
  output logic            syncLock,
  output logic            ookBit
);
  agc_avg_if link ();

  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_regRdData;
  logic [1:0] hystSel;
  logic [1:0] waitSel;
  logic [1:0] hold;
  logic [1:0] lenSel;

  agc_state_t state;
  agc_state_t next_state;
  logic [5:0] waitCnt;
  logic [5:0] next_waitCnt;
  logic       startPulse;
  logic       next_startPulse;
  logic [2:0] next_analogGain;
  logic [2:0] next_digitalGain;
  logic       next_gainStep;
  logic       lastDown;
  logic       next_lastDown;
  logic       next_syncLock;
  logic [7:0] peak;
  logic [7:0] next_peak;
  logic       next_ookBit;

  logic       locked;
  logic       analogOk;
  logic       digitalOk;
  logic [8:0] hiLim;
  logic [7:0] loLim;
  logic       tooHigh;
  logic       tooLow;

  assign hystSel = ctrl[HYST_MSB:HYST_LSB];
  assign waitSel = ctrl[WAIT_MSB:WAIT_LSB];
  assign hold    = ctrl[HOLD_MSB:HOLD_LSB];
  assign lenSel  = ctrl[LEN_MSB:LEN_LSB];

  assign link.lenSel      = lenSel;
  assign link.start       = startPulse;
  assign link.sampleValid = sampleValid;
  assign link.sampleMag   = sampleMag;

  agc_avg agc_avg_i (
    .clock (clock),
    .rst   (rst),
    .link  (link)
  );

  // Register port: reads of other addresses return zero.
  always_comb begin
    next_ctrl      = ctrl;
    next_regRdData = 8'h00;
    if (regWrEn && regAddr == GAIN_CTRL_ADDR) begin
      next_ctrl = regWrData;
    end
    if (regRdEn && regAddr == GAIN_CTRL_ADDR) begin
      next_regRdData = ctrl;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl      <= GAIN_CTRL_RESET;
      regRdData <= 8'h00;
    end else begin
      ctrl      <= next_ctrl;
      regRdData <= next_regRdData;
    end
  end

  // A sync word arriving with the receive restart still locks the gain.
  assign next_syncLock = syncFound | (syncLock & ~rxStart);
  assign locked        = syncLock | syncFound;

  assign analogOk  = (hold == HOLD_NONE) ||
                     (hold == HOLD_SYNC && !locked);
  assign digitalOk = analogOk || (hold == HOLD_ANALOG);

  // The extra margin only applies against the last step's direction, so a
  // level near a threshold does not make the gain bounce back and forth.
  always_comb begin
    hiLim = {1'b0, MAG_TARGET} + {5'h00, DEAD_UP[hystSel]};
    loLim = MAG_TARGET - {4'h0, DEAD_DOWN[hystSel]};
    if (lastDown) begin
      loLim = loLim - {4'h0, HYST_EXTRA[hystSel]};
    end else begin
      hiLim = hiLim + {5'h00, HYST_EXTRA[hystSel]};
    end
    tooHigh = {1'b0, link.avg} > hiLim;
    tooLow  = link.avg < loLim;
  end

  always_comb begin
    next_state       = state;
    next_waitCnt     = waitCnt;
    next_startPulse  = 1'b0;
    next_analogGain  = analogGain;
    next_digitalGain = digitalGain;
    next_gainStep    = 1'b0;
    next_lastDown    = lastDown;
    case (state)
      AGC_WAIT: begin
        if (sampleValid) begin
          // A shorter wait written while counting must still end the wait.
          if (waitCnt >= WAIT_SAMPLES[waitSel] - 6'h01) begin
            next_startPulse = 1'b1;
            next_state      = AGC_ACC;
          end else begin
            next_waitCnt = waitCnt + 6'h01;
          end
        end
      end
      AGC_ACC: begin
        if (link.done) begin
          if (tooHigh && analogOk && analogGain != GAIN_MIN) begin
            next_analogGain = analogGain - 3'h1;
            next_gainStep   = 1'b1;
            next_lastDown   = 1'b1;
          end else if (tooHigh && digitalOk &&
                       digitalGain != GAIN_MIN) begin
            next_digitalGain = digitalGain - 3'h1;
            next_gainStep    = 1'b1;
            next_lastDown    = 1'b1;
          end else if (tooLow && analogOk && analogGain != GAIN_MAX) begin
            next_analogGain = analogGain + 3'h1;
            next_gainStep   = 1'b1;
            next_lastDown   = 1'b0;
          end else if (tooLow && digitalOk &&
                       digitalGain != GAIN_MAX) begin
            next_digitalGain = digitalGain + 3'h1;
            next_gainStep    = 1'b1;
            next_lastDown    = 1'b0;
          end
          if (next_gainStep) begin
            next_waitCnt = 6'h00;
            next_state   = AGC_WAIT;
          end else begin
            next_startPulse = 1'b1;
          end
        end
      end
      default: begin
        next_state   = AGC_WAIT;
        next_waitCnt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state       <= AGC_WAIT;
      waitCnt     <= 6'h00;
      startPulse  <= 1'b0;
      analogGain  <= GAIN_MAX;
      digitalGain <= GAIN_MAX;
      gainStep    <= 1'b0;
      lastDown    <= 1'b0;
      syncLock    <= 1'b0;
    end else begin
      state       <= next_state;
      waitCnt     <= next_waitCnt;
      startPulse  <= next_startPulse;
      analogGain  <= next_analogGain;
      digitalGain <= next_digitalGain;
      gainStep    <= next_gainStep;
      lastDown    <= next_lastDown;
      syncLock    <= next_syncLock;
    end
  end

  // The peak reference restarts from each new average so that it follows
  // slow fading; a burst shorter than one window is still tracked.
  always_comb begin
    next_peak   = peak;
    next_ookBit = 1'b0;
    if (sampleValid && sampleMag > peak) begin
      next_peak = sampleMag;
    end
    if (link.done) begin
      next_peak = link.avg;
    end
    if (ookMode && sampleValid) begin
      next_ookBit = ({1'b0, sampleMag} + {4'h0, OOK_BOUND_DB[lenSel]}) >=
                    {1'b0, peak};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      peak   <= 8'h00;
      ookBit <= 1'b0;
    end else begin
      peak   <= next_peak;
      ookBit <= next_ookBit;
    end
  end

  // Independent count of settling samples, kept only for the wait check.
  logic [5:0] settleSeen;
  logic [5:0] next_settleSeen;

  always_comb begin
    next_settleSeen = settleSeen;
    if (state != AGC_WAIT) begin
      next_settleSeen = 6'h00;
    end else if (sampleValid && settleSeen != 6'h3F) begin
      next_settleSeen = settleSeen + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      settleSeen <= 6'h00;
    end else begin
      settleSeen <= next_settleSeen;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_reset_value: assert property (
    $past(rst) |-> ctrl == GAIN_CTRL_RESET)
    else $error("Configuration did not come out of reset at its default.");

  a_reg_readback: assert property (
    (regRdEn && regAddr == GAIN_CTRL_ADDR && !regWrEn)
    |=> regRdData == $past(ctrl))
    else $error("Register read did not return the stored value.");

  a_write_live: assert property (
    (regWrEn && regAddr == GAIN_CTRL_ADDR) ##1
    (regRdEn && regAddr == GAIN_CTRL_ADDR)
    |=> regRdData == $past(regWrData, 2))
    else $error("Read after write did not return the written value.");

  a_normal_step: assert property (
    (hold == HOLD_NONE && state == AGC_ACC && link.done && tooHigh &&
     analogGain != GAIN_MIN)
    |=> gainStep && analogGain == 3'($past(analogGain) - 3'h1))
    else $error("Normal mode missed a needed gain reduction.");

  a_dead_zone: assert property (
    (state == AGC_ACC && link.done &&
     link.avg <= MAG_TARGET + 8'(DEAD_UP[hystSel]) &&
     link.avg >= MAG_TARGET - 8'(DEAD_UP[hystSel]) &&
     link.avg >= MAG_TARGET - 8'(DEAD_DOWN[hystSel]))
    |=> !gainStep)
    else $error("Gain changed inside the dead zone.");

  a_sync_hold: assert property (
    (hold == HOLD_SYNC && locked)
    |=> $stable(analogGain) && $stable(digitalGain))
    else $error("Gain moved after a sync word in sync hold mode.");

  a_hold_analog: assert property (
    hold == HOLD_ANALOG |=> $stable(analogGain))
    else $error("Analogue gain moved while held.");

  a_hold_all: assert property (
    hold == HOLD_ALL |=> $stable(analogGain) && $stable(digitalGain))
    else $error("Gain moved while fully held.");

  a_wait_len: assert property (
    (state == AGC_WAIT && sampleValid &&
     settleSeen == WAIT_SAMPLES[waitSel] - 6'h01)
    |=> startPulse && state == AGC_ACC)
    else $error("Settling wait did not end at the selected sample count.");

  a_step_restart: assert property (
    gainStep |-> state == AGC_WAIT && waitCnt == 6'h00 && !startPulse)
    else $error("Gain step did not restart the settling wait.");

  a_ook_bound: assert property (
    (ookMode && sampleValid) |=> ookBit ==
    (({1'b0, $past(sampleMag)} + {4'h0, OOK_BOUND_DB[$past(lenSel)]}) >=
     {1'b0, $past(peak)}))
    else $error("OOK decision used the wrong boundary.");

  c_gain_down: cover property (gainStep && lastDown);
  c_gain_up:   cover property (gainStep && !lastDown);
  c_sync_lock: cover property (hold == HOLD_SYNC && syncLock && link.done);
  c_ook_one:   cover property (ookMode && ookBit);
endmodule

/* logic/agc_pkg.sv */
package agc_pkg;
  localparam logic [5:0] GAIN_CTRL_ADDR  = 6'h1C;
  localparam logic [7:0] GAIN_CTRL_RESET = 8'h91;
  localparam int HYST_MSB = 7;
  localparam int HYST_LSB = 6;
  localparam int WAIT_MSB = 5;
  localparam int WAIT_LSB = 4;
  localparam int HOLD_MSB = 3;
  localparam int HOLD_LSB = 2;
  localparam int LEN_MSB  = 1;
  localparam int LEN_LSB  = 0;
  localparam logic [1:0] HOLD_NONE   = 2'h0;
  localparam logic [1:0] HOLD_SYNC   = 2'h1;
  localparam logic [1:0] HOLD_ANALOG = 2'h2;
  localparam logic [1:0] HOLD_ALL    = 2'h3;
  localparam logic [5:0] WAIT_SAMPLES [4] = '{6'h08, 6'h10, 6'h18, 6'h20};
  localparam logic [6:0] AVG_SAMPLES  [4] = '{7'h08, 7'h10, 7'h20, 7'h40};
  localparam logic [2:0] AVG_SHIFT    [4] = '{3'h3, 3'h4, 3'h5, 3'h6};
  localparam logic [4:0] OOK_BOUND_DB [4] = '{5'h04, 5'h08, 5'h0C, 5'h10};
  localparam logic [3:0] DEAD_UP      [4] = '{4'h2, 4'h3, 4'h4, 4'h6};
  localparam logic [3:0] DEAD_DOWN    [4] = '{4'h2, 4'h2, 4'h3, 4'h4};
  localparam logic [3:0] HYST_EXTRA   [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
  localparam logic [7:0] MAG_TARGET = 8'h50;
  localparam logic [2:0] GAIN_MAX   = 3'h7;
  localparam logic [2:0] GAIN_MIN   = 3'h0;
  typedef enum {AGC_WAIT, AGC_ACC} agc_state_t;
endpackage

/* tb/agc_gain_loop_tb.sv */
`timescale 1ns/1ps
module agc_gain_loop_tb import agc_pkg::*;;
  localparam logic [7:0] PAT   [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
  localparam logic [7:0] LDIFF [4] = '{8'h00, 8'h08, 8'h18, 8'h38};
  localparam logic [7:0] BOUND [4] = '{8'h04, 8'h08, 8'h0C, 8'h10};
  logic       clock       = 1'b0;
  logic       rst         = 1'b1;
  logic [5:0] regAddr     = 6'h00;
  logic       regWrEn     = 1'b0;
  logic [7:0] regWrData   = 8'h00;
  logic       regRdEn     = 1'b0;
  logic [7:0] regRdData;
  logic       sampleValid;
  logic [7:0] sampleMag;
  logic       syncFound   = 1'b0;
  logic       rxStart     = 1'b0;
  logic       ookMode     = 1'b0;
  logic [2:0] analogGain;
  logic [2:0] digitalGain;
  logic       gainStep;
  logic       syncLock;
  logic       ookBit;
  logic [7:0] level       = 8'hC0;
  logic       slow        = 1'b0;
  int         failCount   = 0;
  int         checked     = 0;

  always #5 clock = ~clock;

  agc_gain_loop agc_gain_loop_i (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .sampleValid(sampleValid), .sampleMag(sampleMag),
    .syncFound(syncFound), .rxStart(rxStart), .ookMode(ookMode),
    .analogGain(analogGain), .digitalGain(digitalGain),
    .gainStep(gainStep), .syncLock(syncLock), .ookBit(ookBit));

  agc_rx_model agc_rx_model_i (
    .clock(clock), .level(level), .slow(slow), .analogGain(analogGain),
    .digitalGain(digitalGain), .sampleValid(sampleValid),
    .sampleMag(sampleMag));

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task giveVerdict;
    $display("checks=%0d mismatches=%0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task doReset;
    @(posedge clock) rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clock) regWrEn <= 1'b0;
  endtask

  task rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock) regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  // Write and read back on consecutive edges, with no idle cycle between.
  task wrRd(input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clock);
    regWrEn   <= 1'b0;
    regRdEn   <= 1'b1;
    @(posedge clock) regRdEn <= 1'b0;
    #1 q = regRdData;
  endtask

  // Returns the cycle count to the next gain step, or 0 when none came.
  task waitStep(input int lim, output int n);
    n = 0;
    for (int i = 1; i <= lim && n == 0; i++) begin
      @(posedge clock);
      #1;
      if (gainStep === 1'b1) n = i;
    end
  endtask

  // The span between two steps shows the wait and averaging lengths.
  task meas(input logic [7:0] c, output int iv);
    int n;
    doReset;
    level <= 8'hC0;
    wr(GAIN_CTRL_ADDR, c);
    waitStep(300, n);
    waitStep(300, iv);
  endtask

  task dip(input logic [7:0] depth, input logic [7:0] exp);
    // Longer than the 64-sample window, so no average holds an older dip.
    repeat (70) @(posedge clock);
    level <= 8'h60 - depth;
    @(posedge clock) level <= 8'h60;
    #1 chk(8'(ookBit), exp);
  endtask

  initial begin
    logic [7:0] d;
    int         base;
    int         iv;
    int         n;
    doReset;
    rd(GAIN_CTRL_ADDR, d);
    chk(d, 8'h91);
    chk(8'(analogGain), 8'h07);
    for (int i = 0; i < 4; i++) begin
      wrRd(GAIN_CTRL_ADDR, PAT[i], d);
      chk(d, PAT[i]);
    end
    wr(6'h1D, 8'h3C);
    rd(GAIN_CTRL_ADDR, d);
    chk(d, 8'hA5);
    rd(6'h1D, d);
    chk(d, 8'h00);
    meas(8'h00, base);
    chk(8'(analogGain), 8'h05);
    chk(8'(digitalGain), 8'h07);
    for (int i = 1; i < 4; i++) begin
      meas(8'(i << 4), iv);
      chk(8'(iv - base), 8'(8 * i));
      meas(8'(i), iv);
      chk(8'(iv - base), LDIFF[i]);
    end
    // A deviation of 5 dB lies outside the zones of settings 0 and 1 only.
    doReset;
    level <= 8'h2B;
    wr(GAIN_CTRL_ADDR, 8'h00);
    waitStep(300, n);
    chk(8'(n != 0), 8'h01);
    doReset;
    wr(GAIN_CTRL_ADDR, 8'hC0);
    waitStep(300, n);
    chk(8'(n != 0), 8'h00);
    for (int h = 1; h < 3; h++) begin
      doReset;
      wr(GAIN_CTRL_ADDR, 8'(h << 6));
      waitStep(300, n);
      chk(8'(n != 0), 8'(h == 1));
    end
    doReset;
    level <= 8'hC0;
    wr(GAIN_CTRL_ADDR, 8'h08);
    waitStep(300, n);
    chk(8'(analogGain), 8'h07);
    chk(8'(digitalGain), 8'h06);
    doReset;
    slow <= 1'b1;
    wr(GAIN_CTRL_ADDR, 8'h0C);
    waitStep(400, n);
    chk(8'(n != 0), 8'h00);
    chk({2'b00, analogGain, digitalGain}, 8'h3F);
    doReset;
    slow <= 1'b0;
    wr(GAIN_CTRL_ADDR, 8'h04);
    @(posedge clock) syncFound <= 1'b1;
    @(posedge clock) syncFound <= 1'b0;
    #1 chk(8'(syncLock), 8'h01);
    waitStep(300, n);
    chk(8'(n != 0), 8'h00);
    @(posedge clock) rxStart <= 1'b1;
    @(posedge clock) rxStart <= 1'b0;
    #1 chk(8'(syncLock), 8'h00);
    waitStep(300, n);
    chk(8'(n != 0), 8'h01);
    doReset;
    level   <= 8'h60;
    ookMode <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(GAIN_CTRL_ADDR, 8'h0C | 8'(s));
      dip(BOUND[s], 8'h01);
      dip(BOUND[s] + 8'h01, 8'h00);
    end
    giveVerdict;
  end

  initial begin
    repeat (50000) @(posedge clock);
    failCount++;
    giveVerdict;
  end
endmodule

/* tb/agc_rx_model.sv */
`timescale 1ns/1ps
module agc_rx_model (
  input  wire logic       clock,
  input  wire logic [7:0] level,
  input  wire logic       slow,
  input  wire logic [2:0] analogGain,
  input  wire logic [2:0] digitalGain,
  output logic            sampleValid,
  output logic      [7:0] sampleMag
);
  logic [8:0] sum;
  logic       phase = 1'b0;

  // Each analogue step is worth 4 dB and each digital step 2 dB here.
  assign sum = {1'b0, level} + 9'(analogGain) * 9'h4
             + 9'(digitalGain) * 9'h2;
  assign sampleValid = phase;

  // Slow mode delivers a sample on every second cycle only.
  always @(posedge clock) begin
    phase <= slow ? ~phase : 1'b1;
  end

  // Between samples the line carries the inverse, so no stale value passes.
  always_comb begin
    sampleMag = sum[8] ? 8'hFF : sum[7:0];
    if (!sampleValid) begin
      sampleMag = ~sampleMag;
    end
  end
endmodule
